/* typewriter_char_codec.sv */
`timescale 1ns/1ns
`default_nettype none
`include "typewriter_char_codec_regs.svh"

module typewriter_char_codec
    import typewriter_char_codec_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    // program output command
    input wire logic out_valid,
    input wire out_req_s out_req,
    output logic out_ready,
    // program input command
    output logic in_valid,
    output in_char_s in_char,
    output logic in_overrun,
    input wire logic in_take,
    // typewriter channel pins
    output logic [`TW_CODE_W-1:0] tw_out_data,
    output logic tw_out_strobe,
    input wire logic tw_ready,
    input wire logic [`TW_CODE_W-1:0] tw_in_data,
    input wire logic tw_in_strobe,
    // general external word channel, program side
    input wire logic ext_out_valid,
    input wire logic [`EXT_WORD_W-1:0] ext_out_word,
    output logic ext_out_ready,
    output logic ext_in_valid,
    output logic [`EXT_WORD_W-1:0] ext_in_word,
    input wire logic ext_in_take,
    // general external word channel, pins
    output logic [`EXT_WORD_W-1:0] ext_out_data,
    output logic ext_out_strobe,
    input wire logic [`EXT_WORD_W-1:0] ext_in_data,
    input wire logic ext_in_strobe
);

    localparam logic [`TW_CODE_W-1:0] letter_tab [`LETTER_COUNT] = `LETTER_TABLE;
    localparam logic [`TW_CODE_W-1:0] digit_tab [8] = `DIGIT_TABLE;
    localparam logic [`TW_CNT_W-1:0] strobe_last = `TW_CNT_W'(`TW_STROBE_CYCLES - 1);
    localparam logic [`TW_CNT_W-1:0] guard_last = `TW_CNT_W'(`TW_GUARD_CYCLES - 1);

    // command to six-bit code
    function automatic logic [`TW_CODE_W-1:0] encode(input out_req_s r);
        logic [`TW_CODE_W-1:0] c;
        c = r.raw;
        case (r.kind)
            OUT_RAW: c = r.raw;
            OUT_DIGIT: c = digit_tab[r.value[2:0]]; // RULE5
            OUT_LETTER: begin
                // one code per letter, case is separate
                if (r.value < 5'(`LETTER_COUNT)) begin
                    c = letter_tab[r.value]; // RULE4
                end else begin
                    c = `CODE_DELETE;
                end
            end
            OUT_SPACE: c = `CODE_SPACE; // RULE6
            OUT_SHIFT_UP: c = `CODE_SHIFT_UP; // RULE7
            OUT_SHIFT_DOWN: c = `CODE_SHIFT_DOWN; // RULE7
            OUT_CR: c = `CODE_CR; // RULE8
            OUT_TAB: c = `CODE_TAB; // RULE10
            OUT_STOP: c = `CODE_STOP; // RULE9
            OUT_DELETE: c = `CODE_DELETE; // RULE9
            default: c = r.raw;
        endcase
        return c;
    endfunction : encode

    // six-bit code and digit hits to digit, return or invalid
    function automatic in_char_s decode(input logic [`TW_CODE_W-1:0] code,
        input logic [7:0] hit);
        in_char_s d;
        d = '0;
        d.code = code;
        case (hit)
            8'h01: d.digit = 3'h0; // RULE12
            8'h02: d.digit = 3'h1;
            8'h04: d.digit = 3'h2;
            8'h08: d.digit = 3'h3;
            8'h10: d.digit = 3'h4;
            8'h20: d.digit = 3'h5;
            8'h40: d.digit = 3'h6;
            8'h80: d.digit = 3'h7;
            default: d.digit = 3'h0;
        endcase
        d.is_digit = |hit; // RULE12
        d.is_cr = (code == `CODE_CR); // RULE8
        d.invalid = !d.is_digit && !d.is_cr; // RULE12
        return d;
    endfunction : decode

    // pin synchronisers
    logic tw_ready_s1, tw_ready_s2;
    logic [`TW_CODE_W-1:0] tw_data_s1, tw_data_s2;
    logic tw_stb_s1, tw_stb_s2, tw_stb_s3;
    logic [`EXT_WORD_W-1:0] ext_data_s1, ext_data_s2;
    logic ext_stb_s1, ext_stb_s2, ext_stb_s3;
    logic next_tw_ready_s1, next_tw_ready_s2;
    logic [`TW_CODE_W-1:0] next_tw_data_s1, next_tw_data_s2;
    logic next_tw_stb_s1, next_tw_stb_s2, next_tw_stb_s3;
    logic [`EXT_WORD_W-1:0] next_ext_data_s1, next_ext_data_s2;
    logic next_ext_stb_s1, next_ext_stb_s2, next_ext_stb_s3;

    // each stage takes the one before it
    always_comb begin
        next_tw_ready_s1 = tw_ready;
        next_tw_ready_s2 = tw_ready_s1;
        next_tw_data_s1 = tw_in_data; // RULE1
        next_tw_data_s2 = tw_data_s1;
        next_tw_stb_s1 = tw_in_strobe;
        next_tw_stb_s2 = tw_stb_s1;
        next_tw_stb_s3 = tw_stb_s2;
        next_ext_data_s1 = ext_in_data; // RULE3
        next_ext_data_s2 = ext_data_s1;
        next_ext_stb_s1 = ext_in_strobe;
        next_ext_stb_s2 = ext_stb_s1;
        next_ext_stb_s3 = ext_stb_s2;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tw_ready_s1 <= 1'b0;
            tw_ready_s2 <= 1'b0;
            tw_data_s1 <= '0;
            tw_data_s2 <= '0;
            tw_stb_s1 <= 1'b0;
            tw_stb_s2 <= 1'b0;
            tw_stb_s3 <= 1'b0;
            ext_data_s1 <= '0;
            ext_data_s2 <= '0;
            ext_stb_s1 <= 1'b0;
            ext_stb_s2 <= 1'b0;
            ext_stb_s3 <= 1'b0;
        end else begin
            tw_ready_s1 <= next_tw_ready_s1;
            tw_ready_s2 <= next_tw_ready_s2;
            tw_data_s1 <= next_tw_data_s1;
            tw_data_s2 <= next_tw_data_s2;
            tw_stb_s1 <= next_tw_stb_s1;
            tw_stb_s2 <= next_tw_stb_s2;
            tw_stb_s3 <= next_tw_stb_s3;
            ext_data_s1 <= next_ext_data_s1;
            ext_data_s2 <= next_ext_data_s2;
            ext_stb_s1 <= next_ext_stb_s1;
            ext_stb_s2 <= next_ext_stb_s2;
            ext_stb_s3 <= next_ext_stb_s3;
        end
    end

    wire logic tw_rise = tw_stb_s2 && !tw_stb_s3;
    wire logic ext_rise = ext_stb_s2 && !ext_stb_s3;

    // one comparator per digit table entry
    logic [7:0] digit_hit;
    for (genvar g = 0; g < 8; g++) begin : g_digit
        assign digit_hit[g] = (tw_data_s2 == digit_tab[g]); // RULE5 RULE12
    end

    // output sequencer toward the typewriter
    tx_state_e tx_state, next_tx_state;
    logic [`TW_CNT_W-1:0] tx_cnt, next_tx_cnt;
    logic [`TW_CODE_W-1:0] next_tw_out_data;
    logic next_tw_out_strobe;

    // one code per accepted command, no queue
    assign out_ready = (tx_state == TX_IDLE) && tw_ready_s2; // RULE2

    always_comb begin
        next_tx_state = tx_state;
        next_tx_cnt = tx_cnt;
        next_tw_out_data = tw_out_data;
        next_tw_out_strobe = tw_out_strobe;
        case (tx_state)
            TX_IDLE: begin
                if (out_valid && out_ready) begin
                    next_tw_out_data = encode(out_req); // RULE1
                    next_tw_out_strobe = 1'b1;
                    next_tx_cnt = strobe_last;
                    next_tx_state = TX_SEND;
                end
            end
            TX_SEND: begin
                if (tx_cnt == '0) begin
                    next_tw_out_strobe = 1'b0;
                    next_tx_cnt = guard_last;
                    next_tx_state = TX_GUARD;
                end else begin
                    next_tx_cnt = tx_cnt - 1'b1;
                end
            end
            TX_GUARD: begin
                // give the ready pin time to fall through the synchroniser
                if (tx_cnt == '0) begin
                    next_tx_state = TX_IDLE;
                end else begin
                    next_tx_cnt = tx_cnt - 1'b1;
                end
            end
            default: begin
                next_tx_state = TX_IDLE;
                next_tw_out_strobe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_state <= TX_IDLE;
            tx_cnt <= '0;
            tw_out_data <= '0;
            tw_out_strobe <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            tx_cnt <= next_tx_cnt;
            tw_out_data <= next_tw_out_data;
            tw_out_strobe <= next_tw_out_strobe;
        end
    end

    // input holding from the typewriter
    logic next_in_valid, next_in_overrun;
    in_char_s next_in_char;

    always_comb begin
        next_in_valid = in_valid;
        next_in_overrun = in_overrun;
        next_in_char = in_char;
        if (in_take) begin
            next_in_valid = 1'b0; // RULE2
            next_in_overrun = 1'b0;
        end
        // a new character wins over a take in the same cycle
        if (tw_rise) begin
            next_in_char = decode(tw_data_s2, digit_hit); // RULE12
            next_in_valid = 1'b1;
            next_in_overrun = in_overrun || (in_valid && !in_take);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            in_valid <= 1'b0;
            in_overrun <= 1'b0;
            in_char <= '0;
        end else begin
            in_valid <= next_in_valid;
            in_overrun <= next_in_overrun;
            in_char <= next_in_char;
        end
    end

    // fifteen-bit word channel, outbound
    logic next_ext_out_strobe;
    logic [`EXT_WORD_W-1:0] next_ext_out_data;

    assign ext_out_ready = !ext_out_strobe;

    always_comb begin
        next_ext_out_data = ext_out_data;
        next_ext_out_strobe = 1'b0;
        if (ext_out_valid && ext_out_ready) begin
            next_ext_out_data = ext_out_word; // RULE3
            next_ext_out_strobe = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ext_out_data <= '0;
            ext_out_strobe <= 1'b0;
        end else begin
            ext_out_data <= next_ext_out_data;
            ext_out_strobe <= next_ext_out_strobe;
        end
    end

    // fifteen-bit word channel, inbound; a new word wins over a take
    logic next_ext_in_valid;
    logic [`EXT_WORD_W-1:0] next_ext_in_word;

    always_comb begin
        next_ext_in_valid = ext_in_valid;
        next_ext_in_word = ext_in_word;
        if (ext_in_take) begin
            next_ext_in_valid = 1'b0;
        end
        if (ext_rise) begin
            next_ext_in_word = ext_data_s2; // RULE3
            next_ext_in_valid = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ext_in_valid <= 1'b0;
            ext_in_word <= '0;
        end else begin
            ext_in_valid <= next_ext_in_valid;
            ext_in_word <= next_ext_in_word;
        end
    end

endmodule : typewriter_char_codec
`default_nettype wire

/* typewriter_char_codec_regs.svh */
// Overview of operation
// (RULE1) typewriter traffic uses its own channel, one six-bit code in parallel per transfer
// (RULE2) each word moves on its own program command; no autonomous buffering or block moves
// (RULE3) other external equipment exchanges fifteen-bit words in parallel
// (RULE4) each letter has one code for both cases; case set by shift codes
// (RULE5) digits 0 to 7 encode as 37 52 74 70 64 62 66 72 octal, by table
// (RULE6) space is code 04 octal
// (RULE7) shift up is 47 octal, shift down is 57 octal
// (RULE8) carriage return is 45 octal and ends each assembled input word
// (RULE9) stop code is 43 octal, delete code is 77 octal
// (RULE10) horizontal tab is code 51 octal
// (RULE11) the typewriter prints a copy of each character it punches
// (RULE12) received codes map back to digits; codes outside digits and return are invalid
`ifndef TYPEWRITER_CHAR_CODEC_REGS_SVH
`define TYPEWRITER_CHAR_CODEC_REGS_SVH

`define TW_CODE_W 6
`define EXT_WORD_W 15
`define LETTER_COUNT 26

// letter codes a..z, shared by both cases
`define LETTER_TABLE '{6'h18, 6'h13, 6'h0e, 6'h12, 6'h10, 6'h16, 6'h0b, 6'h05, 6'h0c, \
    6'h1a, 6'h1e, 6'h09, 6'h07, 6'h06, 6'h03, 6'h0d, 6'h1d, 6'h0a, 6'h14, 6'h01, \
    6'h1c, 6'h0f, 6'h19, 6'h17, 6'h15, 6'h11}
// digit codes 0..7
`define DIGIT_TABLE '{6'h1f, 6'h2a, 6'h3c, 6'h38, 6'h34, 6'h32, 6'h36, 6'h3a}

`define CODE_SPACE 6'h04
`define CODE_SHIFT_UP 6'h27
`define CODE_SHIFT_DOWN 6'h2f
`define CODE_CR 6'h25
`define CODE_STOP 6'h23
`define CODE_DELETE 6'h3f
`define CODE_TAB 6'h29

// strobe width and guard time toward the typewriter
`define CLK_PERIOD_NS 50
`define TW_STROBE_NS 1000
`define TW_GUARD_NS 1000
`define TW_STROBE_CYCLES ((`TW_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TW_GUARD_CYCLES ((`TW_GUARD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TW_CNT_W 5

`endif

/* typewriter_char_codec_pkg.sv */
`default_nettype none
`include "typewriter_char_codec_regs.svh"

package typewriter_char_codec_pkg;

    // what an output command asks the channel to send
    typedef enum logic [3:0] {
        OUT_RAW,
        OUT_DIGIT,
        OUT_LETTER,
        OUT_SPACE,
        OUT_SHIFT_UP,
        OUT_SHIFT_DOWN,
        OUT_CR,
        OUT_TAB,
        OUT_STOP,
        OUT_DELETE
    } out_kind_e;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_SEND,
        TX_GUARD
    } tx_state_e;

    // one output command from the program
    typedef struct packed {
        out_kind_e kind;
        logic [4:0] value;
        logic [`TW_CODE_W-1:0] raw;
    } out_req_s;

    // one received character, decoded
    typedef struct packed {
        logic [`TW_CODE_W-1:0] code;
        logic [2:0] digit;
        logic is_digit;
        logic is_cr;
        logic invalid;
    } in_char_s;

endpackage : typewriter_char_codec_pkg
`default_nettype wire

/* typewriter_char_codec_checker.sv */
`timescale 1ns/1ns
`default_nettype none

module typewriter_char_codec_checker
    import typewriter_char_codec_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic out_valid,
    input wire out_req_s out_req,
    input wire logic out_ready,
    input wire logic in_valid,
    input wire in_char_s in_char,
    input wire logic [5:0] tw_out_data,
    input wire logic tw_out_strobe,
    input wire logic ext_out_valid,
    input wire logic [14:0] ext_out_word,
    input wire logic ext_out_ready,
    input wire logic [14:0] ext_out_data,
    input wire logic ext_out_strobe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // a taken command of kind k puts code c on the channel
    property code_p(out_kind_e k, logic [5:0] c);
        out_valid && out_ready && out_req.kind == k |=> tw_out_data == c;
    endproperty
    space_code_a: assert property (code_p(OUT_SPACE, 6'h04)) else $error("bad space");
    shift_up_a: assert property (code_p(OUT_SHIFT_UP, 6'h27)) else $error("bad up");
    return_code_a: assert property (code_p(OUT_CR, 6'h25)) else $error("bad return");
    delete_code_a: assert property (code_p(OUT_DELETE, 6'h3f)) else $error("bad del");
    tab_code_a: assert property (code_p(OUT_TAB, 6'h29)) else $error("bad tab");
    take_launch_a: assert property (out_valid && out_ready |=> $rose(tw_out_strobe)
        && !out_ready) else $error("take did not launch");
    strobe_width_a: assert property ($rose(tw_out_strobe) |-> ##19 tw_out_strobe
        ##1 !tw_out_strobe) else $error("strobe width");
    decode_flags_a: assert property (in_valid |-> in_char.is_cr == (in_char.code == 6'h25)
        && in_char.invalid == !(in_char.is_digit || in_char.is_cr)) else $error("flags");
    ext_word_a: assert property (ext_out_valid && ext_out_ready |=> ext_out_strobe
        && ext_out_data == $past(ext_out_word) ##1 !ext_out_strobe) else $error("word out");
    cover property (out_valid && out_ready && out_req.kind == OUT_DIGIT);
    cover property (in_valid && in_char.invalid);
    cover property (ext_out_strobe);
endmodule : typewriter_char_codec_checker

bind typewriter_char_codec typewriter_char_codec_checker chk (.sys_clk, .rst, .out_valid,
    .out_req, .out_ready, .in_valid, .in_char, .tw_out_data, .tw_out_strobe, .ext_out_valid,
    .ext_out_word, .ext_out_ready, .ext_out_data, .ext_out_strobe);
`default_nettype wire

/* typewriter_model.sv */
`timescale 1ns/1ns
`default_nettype none

module typewriter_model (
    input wire logic sys_clk,
    input wire logic slow,
    input wire logic [5:0] tw_out_data,
    input wire logic tw_out_strobe,
    input wire logic send_go,
    input wire logic [5:0] send_code,
    output logic tw_ready,
    output logic [5:0] printed,
    output logic [5:0] tw_in_data,
    output logic tw_in_strobe
);
    // punch and print each code, then stay busy for 2 cycles, or 60 when slow, and go ready again
    initial begin
        tw_ready = 1'b1;
        printed = 6'h0;
        forever begin
            @(posedge tw_out_strobe);
            @(negedge sys_clk);
            printed = tw_out_data;
            tw_ready = 1'b0;
            repeat (slow ? 60 : 2) @(negedge sys_clk);
            tw_ready = 1'b1;
        end
    end
    // key one code onto the lines, then let them drift
    initial begin
        tw_in_data = 6'h15;
        tw_in_strobe = 1'b0;
        forever begin
            @(posedge send_go);
            tw_in_data = send_code;
            repeat (2) @(negedge sys_clk);
            tw_in_strobe = 1'b1;
            repeat (3) @(negedge sys_clk);
            tw_in_strobe = 1'b0;
            repeat (3) @(negedge sys_clk);
            tw_in_data = ~send_code;
        end
    end
endmodule : typewriter_model
`default_nettype wire

/* tb_typewriter_char_codec.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_typewriter_char_codec
    import typewriter_char_codec_pkg::*;
;
    localparam logic [5:0] letters [26] = '{6'h18, 6'h13, 6'h0e, 6'h12, 6'h10, 6'h16, 6'h0b,
        6'h05, 6'h0c, 6'h1a, 6'h1e, 6'h09, 6'h07, 6'h06, 6'h03, 6'h0d, 6'h1d, 6'h0a, 6'h14,
        6'h01, 6'h1c, 6'h0f, 6'h19, 6'h17, 6'h15, 6'h11};
    localparam logic [5:0] digits [8] = '{6'h1f, 6'h2a, 6'h3c, 6'h38, 6'h34, 6'h32, 6'h36, 6'h3a};
    localparam logic [5:0] specials [7] = '{6'h04, 6'h27, 6'h2f, 6'h25, 6'h29, 6'h23, 6'h3f};
    logic sys_clk, rst, out_valid, out_ready, in_valid, in_overrun, in_take, tw_out_strobe;
    logic tw_ready, tw_in_strobe, ext_out_valid, ext_out_ready, ext_in_valid, ext_in_take;
    logic ext_out_strobe, ext_in_strobe, slow, send_go;
    logic [5:0] tw_out_data, tw_in_data, send_code, printed;
    logic [14:0] ext_out_word, ext_in_word, ext_out_data, ext_in_data;
    logic [15:0] rnd;
    out_req_s out_req;
    in_char_s in_char;
    int mismatches, checks_done, k;

    typewriter_char_codec DUT (.sys_clk, .rst, .out_valid, .out_req, .out_ready, .in_valid,
        .in_char, .in_overrun, .in_take, .tw_out_data, .tw_out_strobe, .tw_ready, .tw_in_data,
        .tw_in_strobe, .ext_out_valid, .ext_out_word, .ext_out_ready, .ext_in_valid,
        .ext_in_word, .ext_in_take, .ext_out_data, .ext_out_strobe, .ext_in_data,
        .ext_in_strobe);
    typewriter_model partner (.sys_clk, .slow, .tw_out_data, .tw_out_strobe, .send_go,
        .send_code, .tw_ready, .printed, .tw_in_data, .tw_in_strobe);

    // 50 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // verdict and end of run
    task automatic stop_test();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    // compare codes and flags
    task automatic cmp_code(logic [5:0] got, logic [5:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_code
    // compare words
    task automatic cmp_word(logic [14:0] got, logic [14:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word
    // code expected for an output command
    function automatic logic [5:0] exp_out(out_kind_e kd, logic [4:0] v, logic [5:0] r);
        case (kd)
            OUT_RAW: return r;
            OUT_DIGIT: return digits[v[2:0]];
            OUT_LETTER: return (v > 5'd25) ? 6'h3f : letters[v];
            default: return specials[kd - OUT_SPACE];
        endcase
    endfunction : exp_out
    // next value of the stimulus shift register
    function automatic logic [15:0] lfsr_next(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    // decode expected for a received code
    function automatic logic [11:0] exp_in(logic [5:0] c);
        exp_in = (c == 6'h25) ? {c, 6'b000010} : {c, 6'b000001};
        for (int i = 0; i < 8; i++) begin
            if (digits[i] == c) exp_in = {c, i[2:0], 3'b100};
        end
    endfunction : exp_in
    // send one command, holding it into two refused cycles
    task automatic send_out(out_kind_e kd, logic [4:0] v, logic [5:0] r);
        for (int n = 0; n < 400 && out_ready !== 1'b1; n++) @(negedge sys_clk);
        if (out_ready !== 1'b1) begin
            mismatches++;
            stop_test();
        end else begin
            out_req = {kd, v, r};
            out_valid = 1'b1;
            repeat (3) @(negedge sys_clk);
            out_valid = 1'b0;
            cmp_code({4'h0, tw_out_strobe, out_ready}, 6'h02);
            cmp_code(tw_out_data, exp_out(kd, v, r));
            cmp_code(printed, exp_out(kd, v, r));
        end
    endtask : send_out
    // have the typewriter key one code
    task automatic push(logic [5:0] c);
        send_code = c;
        send_go = 1'b1;
        @(negedge sys_clk);
        send_go = 1'b0;
        repeat (11) @(negedge sys_clk);
    endtask : push
    // receive a code, optionally over an unread one, then consume it
    task automatic recv(logic [5:0] c, logic ovr);
        logic [11:0] m;
        if (ovr) push(6'h3c);
        push(c);
        m = exp_in(c);
        cmp_code({4'h0, in_valid, in_overrun}, {4'h0, 1'b1, ovr});
        cmp_word({3'h0, in_char & (m[2] ? 12'hfff : 12'hfc7)}, {3'h0, m});
        in_take = 1'b1;
        @(negedge sys_clk);
        in_take = 1'b0;
        @(negedge sys_clk);
        cmp_code({4'h0, in_valid, in_overrun}, 6'h0);
    endtask : recv
    // word out, then the inverse word back in
    task automatic ext_pass(logic [14:0] w);
        ext_out_word = w;
        ext_out_valid = 1'b1;
        ext_in_data = ~w;
        @(negedge sys_clk);
        ext_out_valid = 1'b0;
        ext_in_strobe = 1'b1;
        cmp_word(ext_out_data, w);
        cmp_code({4'h0, ext_out_strobe, ext_out_ready}, 6'h02);
        repeat (3) @(negedge sys_clk);
        ext_in_strobe = 1'b0;
        repeat (5) @(negedge sys_clk);
        cmp_word(ext_in_word, ~w);
        cmp_code({5'h0, ext_in_valid}, 6'h01);
        ext_in_take = 1'b1;
        @(negedge sys_clk);
        ext_in_take = 1'b0;
        cmp_code({5'h0, ext_in_valid}, 6'h00);
        ext_in_data = w;
    endtask : ext_pass
    // main sequence
    initial begin
        {rst, out_valid, in_take, ext_out_valid, ext_in_take, ext_in_strobe, slow} = 7'h01 << 6;
        {out_req, ext_out_word, ext_in_data, send_code, send_go} = '0;
        rnd = 16'h43f4;
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        for (k = 0; k < 7; k++) send_out(out_kind_e'(k + 3), 5'h0, 6'h0);
        slow = 1'b1;
        for (k = 0; k < 8; k++) send_out(OUT_DIGIT, k[4:0], 6'h0);
        slow = 1'b0;
        send_out(OUT_LETTER, 5'd31, 6'h0);
        for (k = 0; k < 12; k++) begin
            rnd = lfsr_next(rnd);
            send_out(OUT_LETTER, rnd[4:0] % 5'd26, 6'h0);
            send_out(OUT_RAW, 5'h0, rnd[13:8]);
            recv(rnd[5:0], 1'b0);
            ext_pass(rnd[14:0]);
        end
        for (k = 0; k < 8; k++) recv(digits[k], k[0]);
        recv(6'h25, 1'b1);
        stop_test();
    end
endmodule : tb_typewriter_char_codec
`default_nettype wire
